// >>> otg_support_pkg.sv
`default_nettype none

package otg_support_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] OFS_OTG_CTRL  = 8'h00;
  localparam logic [7:0] OFS_OTG_STAT  = 8'h01;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h03;
  localparam logic [7:0] OFS_TIMER     = 8'h04;
  localparam logic [7:0] OFS_HW_CONFIG = 8'h05;
  localparam logic [7:0] OFS_CPU_FLAGS = 8'h06;
  localparam logic [7:0] OFS_CPU_MASK  = 8'h07;
  localparam logic [7:0] OFS_PORT_ROLE = 8'h08;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTRL_DRV_VBUS    = 0;
  localparam int CTRL_CHRG_VBUS   = 1;
  localparam int CTRL_DISCHRG     = 2;
  localparam int CTRL_DP_PULLDN   = 3;
  localparam int CTRL_DP_PULLUP   = 4;
  localparam int CTRL_DM_PULLDN   = 5;
  localparam int CTRL_SRP_SEL     = 9;
  localparam int CTRL_SRP_DET_EN  = 10;
  localparam int CTRL_PWR_SAVE    = 11;
  localparam int FLAG_ID          = 0;
  localparam int FLAG_SESS_VLD    = 1;
  localparam int FLAG_SRP         = 5;
  localparam int FLAG_TIMEOUT     = 6;
  localparam int CFG_PIN_EN       = 0;
  localparam int CFG_ACT_HIGH     = 1;
  localparam int CFG_EDGE         = 2;
  localparam int CPU_OTG_SUMMARY  = 9;
  localparam int TIMER_START      = 15;

  // ***************************************************************
  // Reset values and timing
  // ***************************************************************
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [8:0]  MASK_RESET   = 9'h000;
  localparam logic [2:0]  CFG_RESET    = 3'h0;
  localparam int          TICK_NS      = 10000;
  localparam int          CLK_NS       = 100;
  localparam int          TICK_CYCLES  = TICK_NS / CLK_NS;
  localparam int          EDGE_CYCLES  = 4;
  localparam int          SLOW_DIV     = 45;

  typedef enum logic [1:0] {ROLE_OTG, ROLE_HOST, ROLE_PERIPH} role_type;

endpackage : otg_support_pkg

`default_nettype wire

// >>> otg_support_wake_and_port_role.sv
`default_nettype none

module otg_support_wake_and_port_role #(
  parameter int TICK_CYCLES = otg_support_pkg::TICK_CYCLES,
  parameter int EDGE_CYCLES = otg_support_pkg::EDGE_CYCLES,
  parameter int SLOW_DIV    = otg_support_pkg::SLOW_DIV
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        id_pin,
  input  wire logic        port1_mode_sel,
  input  wire logic        b_sess_vld,
  input  wire logic        a_vbus_vld,
  input  wire logic        sess_end,
  input  wire logic        overcurrent,
  input  wire logic        dp_level,
  input  wire logic        dm_level,
  input  wire logic        host_ctrl_irq,
  output logic             shared_irq_pin,
  output logic             drv_vbus,
  output logic             chrg_vbus,
  output logic             dischrg_vbus,
  output logic             dp_pullup,
  output logic             dp_pulldn,
  output logic             dm_pulldn,
  output logic             device_ctrl_suspend,
  output logic             host_ctrl_suspend,
  output logic             pll_en,
  output logic             osc_en,
  output logic             charge_pump_suspend,
  output logic             slow_suspend_clock,
  output logic [1:0]       port1_role,
  output logic             port2_downstream,
  output logic             port2_otg_proto_en
);

  // The counters are 16 and 8 bits wide; larger values would wrap.
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535 ||
      EDGE_CYCLES < 1 || EDGE_CYCLES > 255 ||
      SLOW_DIV < 1 || SLOW_DIV > 65535) begin : bad_params
    $error("otg_support: parameter out of range");
  end

  typedef enum logic {PWR_RUN, PWR_SAVE} pwr_type;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [15:0] otg_ctrl_reg;
  logic [6:0]  stat_prev_reg;
  logic [8:0]  otg_summary_irq_flags_reg;
  logic [8:0]  otg_summary_irq_mask_reg;
  logic [2:0]  host_hw_config_reg;
  logic        otg_summary_irq_en_reg;
  logic [14:0] tmr_target_reg;
  logic [14:0] tmr_count_reg;
  logic        tmr_run_reg;
  logic [15:0] tick_div_reg;
  logic [15:0] slow_div_reg;
  logic        slow_clk_reg;
  logic        irq_seen_reg;
  logic [7:0]  edge_cnt_reg;
  logic        irq_pin_reg;
  pwr_type     pwr_state_reg;
  logic [15:0] rdata_reg;
  logic [1:0]  role_reg;

  // ***************************************************************
  // Status and change detection
  // ***************************************************************
  wire logic [6:0] otg_stat = {a_vbus_vld, dm_level, dp_level,
                               overcurrent, sess_end, b_sess_vld,
                               id_pin};
  wire logic [6:0] stat_chg = otg_stat ^ stat_prev_reg;
  wire logic srp_vbus_evt = b_sess_vld & ~stat_prev_reg[1];
  wire logic srp_line_evt = (dp_level & ~stat_prev_reg[4]) |
                            (dm_level & ~stat_prev_reg[5]);
  wire logic srp_evt = otg_ctrl_reg[otg_support_pkg::CTRL_SRP_DET_EN] &
                       (otg_ctrl_reg[otg_support_pkg::CTRL_SRP_SEL] ?
                        srp_line_evt : srp_vbus_evt);
  wire logic tick = (tick_div_reg == 16'(TICK_CYCLES - 1));
  // Comparing the next count lets the flag land on the final tick.
  wire logic tmr_done = tmr_run_reg & tick &
                        (tmr_count_reg + 15'h1 >= tmr_target_reg);
  wire logic [8:0] flag_set = {stat_chg[5], stat_chg[6], tmr_done,
                               srp_evt, stat_chg[4:0]};

  // ***************************************************************
  // Register port decode
  // ***************************************************************
  wire logic wr_ctrl  = wr && addr == otg_support_pkg::OFS_OTG_CTRL;
  wire logic wr_flags = wr && addr == otg_support_pkg::OFS_IRQ_FLAGS;
  wire logic wr_mask  = wr && addr == otg_support_pkg::OFS_IRQ_MASK;
  wire logic wr_tmr   = wr && addr == otg_support_pkg::OFS_TIMER;
  wire logic wr_cfg   = wr && addr == otg_support_pkg::OFS_HW_CONFIG;
  wire logic wr_cpum  = wr && addr == otg_support_pkg::OFS_CPU_MASK;
  wire logic tmr_start = wr_tmr & wdata[otg_support_pkg::TIMER_START];
  // A flag raised in the cycle of its clear survives, so no event is lost.
  wire logic [8:0] flags_next = flag_set |
                                (otg_summary_irq_flags_reg &
                                 ~(wr_flags ? wdata[8:0] : 9'h000));
  wire logic otg_pending = |(otg_summary_irq_flags_reg & otg_summary_irq_mask_reg);
  wire logic irq_src = (otg_pending & otg_summary_irq_en_reg) |
                       host_ctrl_irq;
  // Idle read data stay zero, so a stale word is never taken twice.
  wire logic [15:0] rd_mux;
  assign rd_mux =
    (addr == otg_support_pkg::OFS_OTG_CTRL)  ? otg_ctrl_reg :
    (addr == otg_support_pkg::OFS_OTG_STAT)  ? {9'h000, otg_stat} :
    (addr == otg_support_pkg::OFS_IRQ_FLAGS) ? {7'h00, otg_summary_irq_flags_reg} :
    (addr == otg_support_pkg::OFS_IRQ_MASK)  ? {7'h00, otg_summary_irq_mask_reg} :
    (addr == otg_support_pkg::OFS_TIMER)     ? {tmr_run_reg, tmr_count_reg} :
    (addr == otg_support_pkg::OFS_HW_CONFIG) ? {13'h0000, host_hw_config_reg} :
    (addr == otg_support_pkg::OFS_CPU_FLAGS) ? {6'h00, otg_pending, 9'h000} :
    (addr == otg_support_pkg::OFS_CPU_MASK)  ?
      {6'h00, otg_summary_irq_en_reg, 9'h000} :
    (addr == otg_support_pkg::OFS_PORT_ROLE) ?
      {13'h0000, pwr_state_reg == PWR_SAVE, role_reg} : 16'h0000;

  // ***************************************************************
  // Power saving
  // ***************************************************************
  // Saving is refused in a session because the link still needs the PLL.
  wire logic in_session = b_sess_vld | a_vbus_vld;
  wire logic wake_evt =
    (srp_evt & otg_summary_irq_mask_reg[otg_support_pkg::FLAG_SRP]) |
    (stat_chg[0] & otg_summary_irq_mask_reg[otg_support_pkg::FLAG_ID]) |
    (srp_vbus_evt & otg_summary_irq_mask_reg[otg_support_pkg::FLAG_SESS_VLD]) |
    wr | rd;
  wire logic save_req = otg_ctrl_reg[otg_support_pkg::CTRL_PWR_SAVE];
  wire logic [15:0] ctrl_next =
    wr_ctrl ? wdata :
    (pwr_state_reg == PWR_SAVE && wake_evt) ?
      (otg_ctrl_reg & ~(16'h0001 << otg_support_pkg::CTRL_PWR_SAVE)) :
      otg_ctrl_reg;
  // The role follows the pins on every clock; software only reads it.
  wire logic [1:0] role_next =
    !port1_mode_sel ? 2'(otg_support_pkg::ROLE_OTG) :
    !id_pin ? 2'(otg_support_pkg::ROLE_HOST) :
    2'(otg_support_pkg::ROLE_PERIPH);

  // ***************************************************************
  // Interrupt pin shaping
  // ***************************************************************
  wire logic cfg_pin_en = host_hw_config_reg[otg_support_pkg::CFG_PIN_EN];
  wire logic cfg_high = host_hw_config_reg[otg_support_pkg::CFG_ACT_HIGH];
  wire logic cfg_edge = host_hw_config_reg[otg_support_pkg::CFG_EDGE];
  // Edge mode emits a fixed pulse per rising request so that a level
  // held by slow software does not look like a string of events.
  wire logic edge_start = irq_src & ~irq_seen_reg;
  wire logic pin_active = cfg_pin_en &
                          (cfg_edge ? (edge_cnt_reg != 8'h00) : irq_src);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      otg_ctrl_reg <= otg_support_pkg::CTRL_RESET;
      stat_prev_reg <= 7'h00;
      otg_summary_irq_flags_reg <= 9'h000;
      otg_summary_irq_mask_reg <= otg_support_pkg::MASK_RESET;
      host_hw_config_reg <= otg_support_pkg::CFG_RESET;
      otg_summary_irq_en_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      otg_ctrl_reg <= ctrl_next;
      stat_prev_reg <= otg_stat;
      otg_summary_irq_flags_reg <= flags_next;
      if (wr_mask) begin
        otg_summary_irq_mask_reg <= wdata[8:0];
      end
      if (wr_cfg) begin
        host_hw_config_reg <= wdata[2:0];
      end
      if (wr_cpum) begin
        otg_summary_irq_en_reg <= wdata[otg_support_pkg::CPU_OTG_SUMMARY];
      end
      rdata_reg <= rd ? rd_mux : 16'h0000;
    end
  end

  // ***************************************************************
  // Timer
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_target_reg <= 15'h0000;
      tmr_count_reg <= 15'h0000;
      tmr_run_reg <= 1'b0;
      tick_div_reg <= 16'h0000;
    end else if (tmr_start) begin
      tmr_target_reg <= wdata[14:0];
      tmr_count_reg <= 15'h0000;
      tmr_run_reg <= wdata[14:0] != 15'h0000;
      tick_div_reg <= 16'h0000;
    end else if (tmr_run_reg) begin
      tick_div_reg <= tick ? 16'h0000 : tick_div_reg + 16'h0001;
      if (tick) begin
        tmr_count_reg <= tmr_count_reg + 15'h0001;
      end
      if (tmr_done) begin
        tmr_run_reg <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Pin, power state and port outputs
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_seen_reg <= 1'b0;
      edge_cnt_reg <= 8'h00;
      irq_pin_reg <= 1'b1;
      pwr_state_reg <= PWR_RUN;
      slow_div_reg <= 16'h0000;
      slow_clk_reg <= 1'b0;
      role_reg <= 2'(otg_support_pkg::ROLE_OTG);
    end else begin
      irq_seen_reg <= irq_src;
      if (edge_start) begin
        edge_cnt_reg <= 8'(EDGE_CYCLES);
      end else if (edge_cnt_reg != 8'h00) begin
        edge_cnt_reg <= edge_cnt_reg - 8'h01;
      end
      irq_pin_reg <= pin_active ~^ cfg_high;
      case (pwr_state_reg)
        PWR_RUN: begin
          if (save_req && !in_session && !wr && !rd) begin
            pwr_state_reg <= PWR_SAVE;
          end
        end
        PWR_SAVE: begin
          if (wake_evt) begin
            pwr_state_reg <= PWR_RUN;
          end
        end
        default: pwr_state_reg <= PWR_RUN;
      endcase
      // The slow clock never stops, so wake detection needs no PLL.
      if (slow_div_reg == 16'(SLOW_DIV - 1)) begin
        slow_div_reg <= 16'h0000;
        slow_clk_reg <= ~slow_clk_reg;
      end else begin
        slow_div_reg <= slow_div_reg + 16'h0001;
      end
      role_reg <= role_next;
    end
  end

  assign rdata = rdata_reg;
  assign shared_irq_pin = irq_pin_reg;
  assign drv_vbus = otg_ctrl_reg[otg_support_pkg::CTRL_DRV_VBUS];
  assign chrg_vbus = otg_ctrl_reg[otg_support_pkg::CTRL_CHRG_VBUS];
  assign dischrg_vbus = otg_ctrl_reg[otg_support_pkg::CTRL_DISCHRG];
  assign dp_pullup = otg_ctrl_reg[otg_support_pkg::CTRL_DP_PULLUP];
  assign dp_pulldn = otg_ctrl_reg[otg_support_pkg::CTRL_DP_PULLDN];
  assign dm_pulldn = otg_ctrl_reg[otg_support_pkg::CTRL_DM_PULLDN];
  assign device_ctrl_suspend = pwr_state_reg == PWR_SAVE;
  assign host_ctrl_suspend = pwr_state_reg == PWR_SAVE;
  assign charge_pump_suspend = pwr_state_reg == PWR_SAVE;
  assign pll_en = pwr_state_reg == PWR_RUN;
  assign osc_en = pwr_state_reg == PWR_RUN;
  assign slow_suspend_clock = slow_clk_reg;
  assign port1_role = role_reg;
  // Port 2 is a fixed internal host: no role swap, no OTG protocols.
  assign port2_downstream = 1'b1;
  assign port2_otg_proto_en = 1'b0;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(id_pin) |=> otg_summary_irq_flags_reg[otg_support_pkg::FLAG_ID])
    else $error("id change did not set its flag");

  flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (otg_summary_irq_flags_reg & otg_summary_irq_mask_reg) == 9'h000 && !host_ctrl_irq &&
    !cfg_edge |=> irq_pin_reg == ~$past(cfg_high))
    else $error("pin active with every flag masked");

  pin_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_pin_en ##1 !$past(cfg_pin_en) |-> irq_pin_reg == ~$past(cfg_high))
    else $error("pin active while disabled");

  level_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_pin_en && !cfg_edge && cfg_high && otg_pending &&
     otg_summary_irq_en_reg) |=> irq_pin_reg)
    else $error("summary did not reach pin");

  edge_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    edge_start |=> edge_cnt_reg == 8'(EDGE_CYCLES))
    else $error("edge pulse length wrong");

  tmr_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tmr_done && !tmr_start |=> !tmr_run_reg &&
    otg_summary_irq_flags_reg[otg_support_pkg::FLAG_TIMEOUT])
    else $error("timer did not stop and flag");

  tick_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick_div_reg <= 16'(TICK_CYCLES - 1))
    else $error("tick divider overran");

  save_enter_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_reg == PWR_RUN ##1 pwr_state_reg == PWR_SAVE
    |-> !$past(in_session) && $past(save_req))
    else $error("power saving entered in session");

  wake_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_reg == PWR_SAVE && (wr || rd) |=> pll_en && osc_en)
    else $error("access did not wake");

  role_a: assert property (@(posedge mclk) disable iff (!rst_n)
    port1_mode_sel && !id_pin |=>
    port1_role == 2'(otg_support_pkg::ROLE_HOST))
    else $error("wrong port 1 role");

  wake_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_reg == PWR_SAVE && !wr && !rd &&
    otg_summary_irq_mask_reg == 9'h000 |=> pwr_state_reg == PWR_SAVE)
    else $error("masked event woke the device");

  srp_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_reg == PWR_SAVE && srp_evt &&
    otg_summary_irq_mask_reg[otg_support_pkg::FLAG_SRP] |=> pll_en && osc_en)
    else $error("srp event did not wake");

  id_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_reg == PWR_SAVE && stat_chg[0] &&
    otg_summary_irq_mask_reg[otg_support_pkg::FLAG_ID] |=> pll_en && osc_en)
    else $error("id change did not wake");

  rd_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");

  slow_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    slow_div_reg == 16'(SLOW_DIV - 1) |=>
    slow_clk_reg != $past(slow_clk_reg))
    else $error("slow clock did not toggle");

endmodule : otg_support_wake_and_port_role

`default_nettype wire

// >>> cpu_model.sv
`default_nettype none

module cpu_model (
  input  wire logic        mclk,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // Register cycles of the processor that runs the state machine
  // ***************************************************************
  initial begin
    addr  = 8'h00;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Control outputs of the software state machine go back this way.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg

  // The pin enable goes last, so a half-armed source cannot fire early.
  task automatic arm_irq(input logic [15:0] m, input logic [15:0] c);
    wr_reg(otg_support_pkg::OFS_HW_CONFIG, c & 16'hfffe);
    wr_reg(otg_support_pkg::OFS_IRQ_MASK, m);
    wr_reg(otg_support_pkg::OFS_CPU_MASK, 16'h0200);
    wr_reg(otg_support_pkg::OFS_HW_CONFIG, c);
  endtask : arm_irq

  task automatic isr(output logic [15:0] cf, fl, st);
    fl = 16'h0000;
    st = 16'h0000;
    rd_reg(otg_support_pkg::OFS_CPU_FLAGS, cf);
    if (cf[9] === 1'b1) begin
      rd_reg(otg_support_pkg::OFS_IRQ_FLAGS, fl);
      if (|fl[4:0]) begin
        rd_reg(otg_support_pkg::OFS_OTG_STAT, st);
      end
    end
  endtask : isr
endmodule : cpu_model

`default_nettype wire

// >>> tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] A_CTRL = otg_support_pkg::OFS_OTG_CTRL;
  localparam logic [7:0] A_STAT = otg_support_pkg::OFS_OTG_STAT;
  localparam logic [7:0] A_FLAG = otg_support_pkg::OFS_IRQ_FLAGS;
  localparam logic [7:0] A_CFG  = otg_support_pkg::OFS_HW_CONFIG;
  logic        mclk, rst_n, wr, rd, id_pin, port1_mode_sel, b_sess_vld;
  logic        a_vbus_vld, sess_end, overcurrent, dp_level, dm_level;
  logic        host_ctrl_irq, shared_irq_pin, drv_vbus, chrg_vbus, s;
  logic        dischrg_vbus, dp_pullup, dp_pulldn, dm_pulldn, pll_en;
  logic        device_ctrl_suspend, host_ctrl_suspend, osc_en;
  logic        charge_pump_suspend, slow_suspend_clock;
  logic        port2_downstream, port2_otg_proto_en;
  logic [1:0]  port1_role;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, d, cf, fl, st;
  int          err_total, num_checks;

  otg_support_wake_and_port_role #(.TICK_CYCLES(4), .SLOW_DIV(2),
    .EDGE_CYCLES(otg_support_pkg::EDGE_CYCLES)) dut (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .id_pin(id_pin),
    .port1_mode_sel(port1_mode_sel), .b_sess_vld(b_sess_vld),
    .a_vbus_vld(a_vbus_vld), .sess_end(sess_end),
    .overcurrent(overcurrent), .dp_level(dp_level), .dm_level(dm_level),
    .host_ctrl_irq(host_ctrl_irq), .shared_irq_pin(shared_irq_pin),
    .drv_vbus(drv_vbus), .chrg_vbus(chrg_vbus),
    .dischrg_vbus(dischrg_vbus), .dp_pullup(dp_pullup),
    .dp_pulldn(dp_pulldn), .dm_pulldn(dm_pulldn),
    .device_ctrl_suspend(device_ctrl_suspend),
    .host_ctrl_suspend(host_ctrl_suspend), .pll_en(pll_en),
    .osc_en(osc_en), .charge_pump_suspend(charge_pump_suspend),
    .slow_suspend_clock(slow_suspend_clock), .port1_role(port1_role),
    .port2_downstream(port2_downstream),
    .port2_otg_proto_en(port2_otg_proto_en));
  cpu_model cpu (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Bit order matches the status word, so a pattern is its own answer.
  task automatic set_in(input logic [6:0] v);
    @(posedge mclk);
    {a_vbus_vld, dm_level, dp_level, overcurrent, sess_end, b_sess_vld,
     id_pin} <= v;
    cyc(2);
  endtask : set_in

  task automatic t_regs;
    logic [15:0] v[4] = '{16'h003f, 16'h0011, 16'h062a, 16'h0000};
    logic [6:0]  p[2] = '{7'h2d, 7'h52};
    chk({12'h0, shared_irq_pin, drv_vbus, pll_en, osc_en}, 16'h000b);
    cpu.wr_reg(A_STAT, 16'hffff);
    cpu.wr_reg(8'h09, 16'hffff);
    cpu.rd_reg(8'h09, d);
    chk(d, 16'h0000);
    cpu.rd_reg(A_STAT, d);
    chk(d, 16'h0000);
    foreach (v[i]) begin
      cpu.wr_reg(A_CTRL, v[i]);
      cyc(1);
      chk({10'h0, dm_pulldn, dp_pullup, dp_pulldn, dischrg_vbus, chrg_vbus,
           drv_vbus}, {10'h0, v[i][5:0]});
      cpu.rd_reg(A_CTRL, d);
      chk(d, v[i]);
    end
    foreach (p[i]) begin
      set_in(p[i]);
      cpu.rd_reg(A_STAT, d);
      chk(d, {9'h0, p[i]});
    end
    set_in(7'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {port1_mode_sel, id_pin} <= i[1:0];
      cyc(2);
      chk({14'h0, port1_role}, i[1] ? (i[0] ? 16'h2 : 16'h1) : 16'h0);
      chk({14'h0, port2_downstream, port2_otg_proto_en}, 16'h2);
    end
    @(posedge mclk);
    port1_mode_sel <= 1'b0;
  endtask : t_regs

  task automatic t_irq;
    int n;
    cpu.wr_reg(A_FLAG, 16'h01ff);
    cpu.arm_irq(16'h0001, 16'h0001);
    cyc(2);
    chk(shared_irq_pin, 1'b1);
    @(posedge mclk);
    id_pin <= ~id_pin;
    cyc(4);
    chk(shared_irq_pin, 1'b0);
    cpu.isr(cf, fl, st);
    chk(cf & 16'h0200, 16'h0200);
    chk(fl, 16'h0001);
    chk(st, {15'h0, id_pin});
    cpu.wr_reg(A_FLAG, 16'h0001);
    cyc(3);
    chk(shared_irq_pin, 1'b1);
    cpu.wr_reg(otg_support_pkg::OFS_IRQ_MASK, 16'h0000);
    @(posedge mclk);
    id_pin <= ~id_pin;
    cyc(4);
    chk(shared_irq_pin, 1'b1);
    cpu.rd_reg(otg_support_pkg::OFS_CPU_FLAGS, d);
    chk(d & 16'h0200, 16'h0000);
    @(posedge mclk);
    host_ctrl_irq <= 1'b1;
    cyc(3);
    chk(shared_irq_pin, 1'b0);
    cpu.wr_reg(A_CFG, 16'h0002);
    cyc(2);
    chk(shared_irq_pin, 1'b0);
    cpu.wr_reg(A_CFG, 16'h0003);
    cyc(2);
    chk(shared_irq_pin, 1'b1);
    @(posedge mclk);
    host_ctrl_irq <= 1'b0;
    cpu.wr_reg(otg_support_pkg::OFS_IRQ_MASK, 16'h0001);
    cyc(2);
    chk(shared_irq_pin, 1'b1);
    cpu.wr_reg(otg_support_pkg::OFS_IRQ_MASK, 16'h0000);
    cpu.wr_reg(A_CFG, 16'h0007);
    cyc(3);
    n = 0;
    @(posedge mclk);
    host_ctrl_irq <= 1'b1;
    repeat (16) begin
      @(negedge mclk);
      n += int'(shared_irq_pin);
    end
    chk(16'(n), 16'(otg_support_pkg::EDGE_CYCLES));
    @(posedge mclk);
    host_ctrl_irq <= 1'b0;
    cpu.wr_reg(A_CFG, 16'h0001);
    // Three ticks of four clocks: flag lands near cycle 13.
    cpu.wr_reg(A_FLAG, 16'h01ff);
    cpu.wr_reg(otg_support_pkg::OFS_TIMER, 16'h8003);
    cyc(8);
    cpu.rd_reg(A_FLAG, d);
    chk(d & 16'h0040, 16'h0000);
    cyc(6);
    cpu.rd_reg(A_FLAG, d);
    chk(d & 16'h0040, 16'h0040);
    cpu.rd_reg(otg_support_pkg::OFS_TIMER, d);
    chk(d & 16'h8000, 16'h0000);
  endtask : t_irq

  // Access wakes the part too, so the mask goes in before the nap starts.
  task automatic nap(input logic [15:0] m, c, input int ev, input logic w);
    cpu.wr_reg(otg_support_pkg::OFS_IRQ_MASK, m);
    cpu.wr_reg(A_CTRL, c);
    cyc(3);
    chk({device_ctrl_suspend, host_ctrl_suspend, charge_pump_suspend,
         pll_en, osc_en}, 16'h001c);
    s = slow_suspend_clock;
    cyc(2);
    chk(slow_suspend_clock, {15'h0, ~s});
    @(posedge mclk);
    if (ev == 0) id_pin <= ~id_pin;
    else if (ev == 1) b_sess_vld <= 1'b1;
    else dp_level <= 1'b1;
    cyc(4);
    chk({pll_en, osc_en}, {14'h0, w, w});
    @(posedge mclk);
    {b_sess_vld, dp_level} <= 2'b00;
    cpu.rd_reg(A_FLAG, d);
    cyc(2);
    chk({device_ctrl_suspend, pll_en, osc_en}, 16'h0003);
  endtask : nap

  task automatic t_power;
    @(posedge mclk);
    b_sess_vld <= 1'b1;
    cpu.wr_reg(A_CTRL, 16'h0800);
    cyc(3);
    chk(pll_en, 1'b1);
    cpu.wr_reg(A_CTRL, 16'h0000);
    set_in(7'h00);
    nap(16'h0001, 16'h0800, 0, 1'b1);
    nap(16'h0000, 16'h0800, 0, 1'b0);
    nap(16'h0002, 16'h0800, 1, 1'b1);
    nap(16'h0020, 16'h0c00, 1, 1'b1);
    nap(16'h0020, 16'h0800, 1, 1'b0);
    nap(16'h0020, 16'h0e00, 2, 1'b1);
    nap(16'h0020, 16'h0c00, 2, 1'b0);
  endtask : t_power

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    stop_test();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    rst_n = 1'b0;
    host_ctrl_irq = 1'b0;
    port1_mode_sel = 1'b0;
    {a_vbus_vld, dm_level, dp_level, overcurrent, sess_end, b_sess_vld,
     id_pin} = 7'h00;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_irq();
    t_power();
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
